// >>> verilog/irq_bank_pkg.sv
package irq_bank_pkg;

	localparam int          NUM_LVL_SRC = 12;
	localparam int          NUM_EN_SRC  = 21;
	localparam int          NUM_SRC     = 33;
	localparam int          LVL_W       = 3;
	localparam int          ID_W        = 6;

	// Word indices; byte address is four times the index
	localparam logic [5:0]  IDX_EN2     = 6'h00;
	localparam logic [5:0]  IDX_EN3     = 6'h01;
	localparam logic [5:0]  IDX_EN4     = 6'h02;
	localparam logic [5:0]  IDX_LVL0    = 6'h03;
	localparam logic [5:0]  IDX_LVL1    = 6'h04;
	localparam logic [5:0]  IDX_LVL2    = 6'h05;
	localparam logic [5:0]  IDX_FLAGS   = 6'h06;
	localparam logic [5:0]  IDX_STATUS  = 6'h07;

	localparam logic [2:0]  EN2_MASK    = 3'h7;
	localparam logic [15:0] EN3_MASK    = 16'h39ff;
	localparam logic [15:0] EN4_MASK    = 16'h00f6;
	localparam logic [15:0] LVL_MASK    = 16'h7777;
	localparam logic [15:0] LVL_RESET   = 16'h4444;
	localparam logic [15:0] EN_RESET    = 16'h0000;

	// Status word fields
	localparam int          ST_FLAG32   = 0;
	localparam int          ST_LVL_LO   = 8;
	localparam int          ST_VALID    = 11;
	localparam int          ST_ID_LO    = 16;

	// Positions in the enable vector of the enable-word sources (after the 12 level sources)
	localparam int          EN_DMA5     = 26;
	localparam int          EN_CANB_EV  = 23;

endpackage : irq_bank_pkg

// >>> verilog/irq_enable_priority_bank.sv
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module irq_enable_priority_bank
	import irq_bank_pkg::*;
(
	input  wire logic                        I_SYS_CLK,
	input  wire logic                        I_RST_N,
	input  wire logic                        I_HSEL,
	input  wire logic [31:0]                 I_HADDR,
	input  wire logic [1:0]                  I_HTRANS,
	input  wire logic                        I_HWRITE,
	input  wire logic [2:0]                  I_HSIZE,
	input  wire logic [31:0]                 I_HWDATA,
	input  wire logic                        I_HREADY,
	output logic      [31:0]                 O_HRDATA,
	output logic                             O_HREADYOUT,
	output logic                             O_HRESP,
	input  wire logic [NUM_SRC-1:0]          I_REQ_FLAG,
	input  wire logic [NUM_LVL_SRC-1:0]      I_LVL_SRC_EN,
	input  wire logic [NUM_EN_SRC*LVL_W-1:0] I_EN_SRC_LEVEL,
	output logic      [NUM_SRC-1:0]          O_SRC_REQ,
	output logic      [NUM_SRC*LVL_W-1:0]    O_SRC_LEVEL,
	output logic                             O_IRQ_VALID,
	output logic      [LVL_W-1:0]            O_IRQ_LEVEL,
	output logic      [ID_W-1:0]             O_IRQ_ID
);

	typedef struct packed {
		logic [2:0]         en2;
		logic [15:0]        en3;
		logic [15:0]        en4;
		logic [15:0]        lvl0;
		logic [15:0]        lvl1;
		logic [15:0]        lvl2;
		logic               wr_pend;
		logic [5:0]         wr_idx;
		logic [31:0]        rdata;
		logic [NUM_SRC-1:0] req;
		logic               valid;
		logic [LVL_W-1:0]   level;
		logic [ID_W-1:0]    id;
	} state_t;

	localparam state_t ST_RESET = '{
		en2: 3'h0, en3: EN_RESET, en4: EN_RESET,
		lvl0: LVL_RESET, lvl1: LVL_RESET, lvl2: LVL_RESET,
		wr_pend: 1'b0, wr_idx: 6'h00, rdata: 32'h0000_0000, req: '0,
		valid: 1'b0, level: 3'h0, id: 6'h00
	};

	state_t                     st_reg;
	state_t                     st_next;
	logic                       rst_meta;
	logic                       rst_sync;
	logic                       ap_valid;
	logic [NUM_SRC-1:0]         en_all;
	logic [NUM_SRC-1:0]         lvl_nz;
	logic [NUM_SRC-1:0]         fwd;
	logic [NUM_SRC*LVL_W-1:0]   lvl_flat;
	logic [NUM_EN_SRC-1:0]      en_bits;
	logic [47:0]                lvl_words;
	logic [LVL_W-1:0]           best_lvl;
	logic [ID_W-1:0]            best_id;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	function automatic logic [31:0] rd_word(input state_t s, input logic [5:0] idx,
			input logic [NUM_SRC-1:0] flags);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (idx)
			IDX_EN2:    w[2:0] = s.en2;
			IDX_EN3:    w[15:0] = s.en3 & EN3_MASK;
			IDX_EN4:    w[15:0] = s.en4 & EN4_MASK;
			IDX_LVL0:   w[15:0] = s.lvl0 & LVL_MASK;
			IDX_LVL1:   w[15:0] = s.lvl1 & LVL_MASK;
			IDX_LVL2:   w[15:0] = s.lvl2 & LVL_MASK;
			IDX_FLAGS:  w = flags[31:0];
			IDX_STATUS: begin
				w[ST_FLAG32] = flags[32];
				w[ST_LVL_LO +: LVL_W] = s.level;
				w[ST_VALID] = s.valid;
				w[ST_ID_LO +: ID_W] = s.id;
			end
			default:    w = 32'h0000_0000;
		endcase
		return w;
	endfunction : rd_word

	assign ap_valid  = I_HSEL && I_HTRANS[1] && I_HREADY;
	assign lvl_words = {st_reg.lvl2, st_reg.lvl1, st_reg.lvl0};
	// Enable-word sources in natural order: word 2, then word 3, then word 4
	assign en_bits   = {st_reg.en4[7:4], st_reg.en4[2:1], st_reg.en3[13:11],
		st_reg.en3[8:0], st_reg.en2};
	assign en_all    = {en_bits, I_LVL_SRC_EN};

	always_comb begin
		lvl_flat = '0;
		for (int i = 0; i < NUM_LVL_SRC; i++) begin
			lvl_flat[i*LVL_W +: LVL_W] = lvl_words[i*4 +: LVL_W];
		end
		lvl_flat[NUM_SRC*LVL_W-1:NUM_LVL_SRC*LVL_W] = I_EN_SRC_LEVEL;
	end

	always_comb begin
		best_lvl = 3'h0;
		best_id  = 6'h00;
		for (int i = 0; i < NUM_SRC; i++) begin
			lvl_nz[i] = lvl_flat[i*LVL_W +: LVL_W] != 3'h0;
			fwd[i]    = I_REQ_FLAG[i] && en_all[i] && lvl_nz[i];
			// Strict compare keeps the lower-numbered source on a tie
			if (fwd[i] && lvl_flat[i*LVL_W +: LVL_W] > best_lvl) begin
				best_lvl = lvl_flat[i*LVL_W +: LVL_W];
				best_id  = ID_W'(i);
			end
		end
	end

	always_comb begin
		st_next = st_reg;
		// Write data arrives in the data phase, one cycle after the address
		if (st_reg.wr_pend) begin
			unique case (st_reg.wr_idx)
				IDX_EN2:  st_next.en2  = I_HWDATA[2:0] & EN2_MASK;
				IDX_EN3:  st_next.en3  = I_HWDATA[15:0] & EN3_MASK;
				IDX_EN4:  st_next.en4  = I_HWDATA[15:0] & EN4_MASK;
				IDX_LVL0: st_next.lvl0 = I_HWDATA[15:0] & LVL_MASK;
				IDX_LVL1: st_next.lvl1 = I_HWDATA[15:0] & LVL_MASK;
				IDX_LVL2: st_next.lvl2 = I_HWDATA[15:0] & LVL_MASK;
				default:  st_next.en2  = st_reg.en2;
			endcase
		end
		st_next.wr_pend = ap_valid && I_HWRITE;
		st_next.wr_idx  = I_HADDR[7:2];
		// Reading from the post-write copy keeps a read right after a write coherent
		st_next.rdata   = (ap_valid && !I_HWRITE) ?
			rd_word(st_next, I_HADDR[7:2], I_REQ_FLAG) : 32'h0000_0000;
		st_next.req     = fwd;
		st_next.valid   = |fwd;
		st_next.level   = best_lvl;
		st_next.id      = best_id;
	end

	always_ff @(posedge I_SYS_CLK or negedge rst_sync) begin
		if (!rst_sync) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_HRDATA    = st_reg.rdata;
	assign O_HREADYOUT = 1'b1;
	assign O_HRESP     = 1'b0;
	assign O_SRC_REQ   = st_reg.req;
	assign O_SRC_LEVEL = lvl_flat;
	assign O_IRQ_VALID = st_reg.valid;
	assign O_IRQ_LEVEL = st_reg.level;
	assign O_IRQ_ID    = st_reg.id;

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!rst_sync);

	reset_values_a: assert property ($rose(rst_sync) |-> st_reg.lvl0 == LVL_RESET
		&& st_reg.lvl2 == LVL_RESET && st_reg.en3 == 16'h0000 && st_reg.en4 == 16'h0000)
		else $error("levels or enables wrong after reset");

	read_mask_a: assert property ((ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_EN3)
		|=> (O_HRDATA & ~{16'h0000, EN3_MASK}) == 32'h0000_0000)
		else $error("unimplemented enable bit read as one");

	dma5_bit_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN3)
		|=> en_all[EN_DMA5] == $past(I_HWDATA[13]) && en_all[EN_CANB_EV] == $past(I_HWDATA[8]))
		else $error("third enable word bit placement wrong");

	timer1_field_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_LVL0)
		|=> lvl_flat[3*LVL_W +: LVL_W] == $past(I_HWDATA[14:12]))
		else $error("timer one level field misplaced");

	enable_gate_a: assert property (1'b1 |=> (st_reg.req & ~$past(en_all)) == '0)
		else $error("disabled source forwarded");

	zero_level_a: assert property (1'b1 |=> (st_reg.req & ~$past(lvl_nz)) == '0)
		else $error("zero level source forwarded");

	winner_valid_a: assert property (st_reg.valid |-> st_reg.req[st_reg.id]
		&& st_reg.level != 3'h0)
		else $error("winner not among forwarded requests");

	for (genvar g = 0; g < NUM_SRC; g++) begin : g_arb_chk
		highest_wins_a: assert property (fwd[g] |=> st_reg.valid
			&& st_reg.level >= $past(lvl_flat[g*LVL_W +: LVL_W])
			&& (st_reg.level != $past(lvl_flat[g*LVL_W +: LVL_W]) || st_reg.id <= g))
			else $error("lower level or later source won");
	end

	// Read-back masks: holes must read zero whatever was written
	en2_mask_a: assert property ((ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_EN2)
		|=> O_HRDATA[31:3] == 29'h0000_0000)
		else $error("second enable word hole read as one");

	en4_mask_a: assert property ((ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_EN4)
		|=> (O_HRDATA & ~{16'h0000, EN4_MASK}) == 32'h0000_0000)
		else $error("fourth enable word hole read as one");

	lvl0_mask_a: assert property ((ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_LVL0)
		|=> (O_HRDATA & ~{16'h0000, LVL_MASK}) == 32'h0000_0000)
		else $error("level word 0 hole read as one");

	lvl1_mask_a: assert property ((ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_LVL1)
		|=> (O_HRDATA & ~{16'h0000, LVL_MASK}) == 32'h0000_0000)
		else $error("level word 1 hole read as one");

	lvl2_mask_a: assert property ((ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_LVL2)
		|=> (O_HRDATA & ~{16'h0000, LVL_MASK}) == 32'h0000_0000)
		else $error("level word 2 hole read as one");

	unmapped_read_a: assert property ((ap_valid && !I_HWRITE && I_HADDR[7:2] > IDX_STATUS)
		|=> O_HRDATA == 32'h0000_0000)
		else $error("unmapped index read nonzero");

	// Read data stands only in its data phase
	idle_rdata_a: assert property (!(ap_valid && !I_HWRITE)
		|=> O_HRDATA == 32'h0000_0000)
		else $error("read data outside a read data phase");

	// Stored words never hold a one in a hole
	en3_holes_a: assert property (st_reg.en3[15:14] == 2'h0
		&& st_reg.en3[10:9] == 2'h0)
		else $error("third enable word hole stored");

	en4_holes_a: assert property (st_reg.en4[15:8] == 8'h00
		&& st_reg.en4[3] == 1'b0 && st_reg.en4[0] == 1'b0)
		else $error("fourth enable word hole stored");

	lvl_holes_a: assert property ((st_reg.lvl0 & ~LVL_MASK) == 16'h0000
		&& (st_reg.lvl1 & ~LVL_MASK) == 16'h0000
		&& (st_reg.lvl2 & ~LVL_MASK) == 16'h0000)
		else $error("level word hole stored");

	// Flag and status words are read-only
	ro_ignore_a: assert property ((st_reg.wr_pend && st_reg.wr_idx >= IDX_FLAGS)
		|=> st_reg.en2 == $past(st_reg.en2) && st_reg.en3 == $past(st_reg.en3)
		&& st_reg.en4 == $past(st_reg.en4) && st_reg.lvl0 == $past(st_reg.lvl0)
		&& st_reg.lvl1 == $past(st_reg.lvl1) && st_reg.lvl2 == $past(st_reg.lvl2))
		else $error("write to read-only word changed a register");

	en_hold_a: assert property (!st_reg.wr_pend
		|=> st_reg.en2 == $past(st_reg.en2) && st_reg.en3 == $past(st_reg.en3)
		&& st_reg.en4 == $past(st_reg.en4))
		else $error("enable word changed without a write");

	lvl_hold_a: assert property (!st_reg.wr_pend
		|=> st_reg.lvl0 == $past(st_reg.lvl0) && st_reg.lvl1 == $past(st_reg.lvl1)
		&& st_reg.lvl2 == $past(st_reg.lvl2))
		else $error("level word changed without a write");

	// Bit placement of every enable-word bit except sources 23 and 26 (checked above), checked against the source number
	codec_bits_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN3)
		|=> en_all[25] == $past(I_HWDATA[12]) && en_all[24] == $past(I_HWDATA[11]))
		else $error("codec enable bits misplaced");

	can_b_rx_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN3)
		|=> en_all[22] == $past(I_HWDATA[7]))
		else $error("CAN B receive enable misplaced");

	ext_pins_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN3)
		|=> en_all[21] == $past(I_HWDATA[6]) && en_all[20] == $past(I_HWDATA[5]))
		else $error("external pin enables misplaced");

	timer_bits_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN3)
		|=> en_all[19] == $past(I_HWDATA[4]) && en_all[18] == $past(I_HWDATA[3])
		&& en_all[15] == $past(I_HWDATA[0]))
		else $error("timer enables misplaced");

	i2c_b_bits_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN3)
		|=> en_all[17] == $past(I_HWDATA[2]) && en_all[16] == $past(I_HWDATA[1]))
		else $error("I2C B enables misplaced");

	can_tx_bits_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN4)
		|=> en_all[32] == $past(I_HWDATA[7]) && en_all[31] == $past(I_HWDATA[6]))
		else $error("CAN transmit enables misplaced");

	dma67_bits_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN4)
		|=> en_all[30] == $past(I_HWDATA[5]) && en_all[29] == $past(I_HWDATA[4]))
		else $error("DMA six or seven enable misplaced");

	uart_err_bits_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN4)
		|=> en_all[28] == $past(I_HWDATA[2]) && en_all[27] == $past(I_HWDATA[1]))
		else $error("UART error enables misplaced");

	en2_bits_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN2)
		|=> en_all[14] == $past(I_HWDATA[2]) && en_all[13] == $past(I_HWDATA[1])
		&& en_all[12] == $past(I_HWDATA[0]))
		else $error("second enable word bits misplaced");

	// Field placement of every level, checked on the per-source output
	lvl0_fields_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_LVL0)
		|=> O_SRC_LEVEL[8:6] == $past(I_HWDATA[10:8])
		&& O_SRC_LEVEL[5:3] == $past(I_HWDATA[6:4])
		&& O_SRC_LEVEL[2:0] == $past(I_HWDATA[2:0]))
		else $error("level word 0 fields misplaced");

	lvl1_fields_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_LVL1)
		|=> O_SRC_LEVEL[23:21] == $past(I_HWDATA[14:12])
		&& O_SRC_LEVEL[20:18] == $past(I_HWDATA[10:8])
		&& O_SRC_LEVEL[17:15] == $past(I_HWDATA[6:4])
		&& O_SRC_LEVEL[14:12] == $past(I_HWDATA[2:0]))
		else $error("level word 1 fields misplaced");

	lvl2_fields_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_LVL2)
		|=> O_SRC_LEVEL[35:33] == $past(I_HWDATA[14:12])
		&& O_SRC_LEVEL[32:30] == $past(I_HWDATA[10:8])
		&& O_SRC_LEVEL[29:27] == $past(I_HWDATA[6:4])
		&& O_SRC_LEVEL[26:24] == $past(I_HWDATA[2:0]))
		else $error("level word 2 fields misplaced");

	src_level_low_a: assert property (O_SRC_LEVEL[11:0] == {st_reg.lvl0[14:12],
		st_reg.lvl0[10:8], st_reg.lvl0[6:4], st_reg.lvl0[2:0]}
		&& O_SRC_LEVEL[23:12] == {st_reg.lvl1[14:12], st_reg.lvl1[10:8],
		st_reg.lvl1[6:4], st_reg.lvl1[2:0]}
		&& O_SRC_LEVEL[35:24] == {st_reg.lvl2[14:12], st_reg.lvl2[10:8],
		st_reg.lvl2[6:4], st_reg.lvl2[2:0]})
		else $error("per-source level output wrong");

	src_level_out_a: assert property (O_SRC_LEVEL[NUM_SRC*LVL_W-1:NUM_LVL_SRC*LVL_W]
		== I_EN_SRC_LEVEL)
		else $error("enable-word source levels not passed through");

	// Forwarding needs all three conditions, and all three suffice
	req_flag_a: assert property (1'b1 |=> (st_reg.req & ~$past(I_REQ_FLAG)) == '0)
		else $error("unflagged source forwarded");

	req_all_a: assert property (1'b1 |=> (($past(I_REQ_FLAG) & $past(en_all)
		& $past(lvl_nz)) & ~st_reg.req) == '0)
		else $error("qualified request not forwarded");

	valid_any_a: assert property (st_reg.valid == (st_reg.req != '0))
		else $error("valid does not match forwarded requests");

	idle_quiet_a: assert property (!st_reg.valid
		|-> st_reg.level == 3'h0 && st_reg.id == 6'h00)
		else $error("level or id shown with no request");

	id_range_a: assert property (st_reg.id < 6'(NUM_SRC))
		else $error("winner id out of range");

	reset_more_a: assert property ($rose(rst_sync) |-> st_reg.en2 == 3'h0
		&& st_reg.lvl1 == LVL_RESET && st_reg.req == '0 && !st_reg.valid
		&& O_HRDATA == 32'h0000_0000)
		else $error("state not quiet after reset");

	// A read right behind a write to the same word sees the new value
	raw_en3_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_EN3
		&& ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_EN3)
		|=> O_HRDATA[15:0] == ($past(I_HWDATA[15:0]) & EN3_MASK))
		else $error("read after write to third enable word stale");

	raw_lvl1_a: assert property ((st_reg.wr_pend && st_reg.wr_idx == IDX_LVL1
		&& ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_LVL1)
		|=> O_HRDATA[15:0] == ($past(I_HWDATA[15:0]) & LVL_MASK))
		else $error("read after write to level word 1 stale");

	// Flags read back regardless of enables
	flags_read_a: assert property ((ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_FLAGS)
		|=> O_HRDATA == $past(I_REQ_FLAG[31:0]))
		else $error("flag word read wrong");

	status_read_a: assert property ((ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_STATUS)
		|=> O_HRDATA[ST_FLAG32] == $past(I_REQ_FLAG[32])
		&& O_HRDATA[ST_VALID] == st_reg.valid
		&& O_HRDATA[ST_LVL_LO +: LVL_W] == st_reg.level
		&& O_HRDATA[ST_ID_LO +: ID_W] == st_reg.id)
		else $error("status word read wrong");

	status_holes_a: assert property ((ap_valid && !I_HWRITE && I_HADDR[7:2] == IDX_STATUS)
		|=> O_HRDATA[31:22] == 10'h000 && O_HRDATA[15:12] == 4'h0
		&& O_HRDATA[7:1] == 7'h00)
		else $error("status word hole read as one");

endmodule : irq_enable_priority_bank
`default_nettype wire

// >>> tb/irq_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_src_model
	import irq_bank_pkg::*;
(
	input  wire logic                        i_clk,
	output logic      [NUM_SRC-1:0]          o_flag,
	output logic      [NUM_LVL_SRC-1:0]      o_lvl_en,
	output logic      [NUM_EN_SRC*LVL_W-1:0] o_en_lvl
);
	initial begin
		o_flag   = '0;
		o_lvl_en = '0;
		o_en_lvl = '0;
	end

	// A raised flag stays up until the next post clears it
	task automatic post(input logic [NUM_SRC-1:0] f, input logic [NUM_LVL_SRC-1:0] e,
			input logic [NUM_EN_SRC*LVL_W-1:0] l);
		@(posedge i_clk);
		o_flag   <= f;
		o_lvl_en <= e;
		o_en_lvl <= l;
	endtask : post
endmodule : irq_src_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import irq_bank_pkg::*;
	logic                  clk    = 1'b0;
	logic                  rst_n  = 1'b0;
	logic                  hsel   = 1'b0;
	logic [31:0]           haddr  = 32'h0;
	logic [1:0]            htrans = 2'h0;
	logic                  hwrite = 1'b0;
	logic [31:0]           hwdata = 32'h0;
	logic [31:0]           rd;
	wire logic [31:0]      hrdata;
	wire logic             hready;
	wire logic             hresp;
	wire logic [32:0]      src_req;
	wire logic [98:0]      src_lvl;
	wire logic             irq_v;
	wire logic [2:0]       irq_l;
	wire logic [5:0]       irq_id;
	wire logic [32:0]      flag;
	wire logic [11:0]      lvl_en;
	wire logic [62:0]      en_lvl;
	logic [31:0]           rst_v [6] = '{0, 0, 0, 32'h4444, 32'h4444, 32'h4444};
	logic [31:0]           msk_v [6] = '{7, 32'h39ff, 32'hf6, 32'h7777, 32'h7777, 32'h7777};
	int                    mismatches = 0;
	int                    comparisons = 0;
	int                    cycles = 0;
	int                    ix;
	int                    b;

	always #5 clk = ~clk;

	irq_src_model src (.i_clk(clk), .o_flag(flag), .o_lvl_en(lvl_en), .o_en_lvl(en_lvl));

	irq_enable_priority_bank uut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
		.I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
		.O_HRESP(hresp), .I_REQ_FLAG(flag), .I_LVL_SRC_EN(lvl_en), .I_EN_SRC_LEVEL(en_lvl),
		.O_SRC_REQ(src_req), .O_SRC_LEVEL(src_lvl), .O_IRQ_VALID(irq_v),
		.O_IRQ_LEVEL(irq_l), .O_IRQ_ID(irq_id));

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	// Address phase held until hready, read data taken at the edge ending the data phase
	task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] wd);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, i, 2'h0};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk_word

	task automatic chk_out(input string n, input logic [35:0] e, input logic [35:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk_out

	// Ceiling well above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 6'(i), 32'h0);
			chk_word("reset value", rst_v[i], rd);
			bus(1'b1, 6'(i), 32'hffffffff);
			bus(1'b0, 6'(i), 32'h0);
			chk_word("writable bits", msk_v[i], rd);
		end
		bus(1'b1, 6'h08, 32'hffffffff);
		bus(1'b0, 6'h08, 32'h0);
		chk_word("unmapped word", 32'h0, rd);
		$display("test registers done");
		for (int i = 3; i < 6; i++)
			bus(1'b1, 6'(i), 32'h1234);
		src.post(33'hf, 12'hfff, 63'h0);
		settle();
		chk_out("level fields", 36'h29c29c29c, src_lvl[35:0]);
		chk_out("winner", {26'h0, 1'b1, 3'd4, 6'd0}, {26'h0, irq_v, irq_l, irq_id});
		bus(1'b1, IDX_LVL0, 32'h7000);
		bus(1'b1, IDX_LVL1, 32'h7000);
		src.post(33'h8f, 12'hfff, 63'h0);
		settle();
		chk_out("zero level", 36'h88, {3'h0, src_req});
		chk_out("tie", {26'h0, 1'b1, 3'd7, 6'd3}, {26'h0, irq_v, irq_l, irq_id});
		src.post(33'h8f, 12'h080, 63'h0);
		settle();
		chk_out("blocked", 36'h80, {3'h0, src_req});
		$display("test levels done");
		src.post('1, 12'h0, {21{3'd1}});
		settle();
		chk_out("source levels high", 36'h249249249, src_lvl[71:36]);
		bus(1'b0, IDX_FLAGS, 32'h0);
		chk_word("flag word", 32'hffffffff, rd);
		bus(1'b0, IDX_STATUS, 32'h0);
		chk_word("status word", 32'h000c0901, rd);
		chk_out("bus response", 36'h0, {35'h0, hresp});
		for (int s = 12; s < 33; s++) begin
			ix = s < 15 ? 0 : (s < 27 ? 1 : 2);
			b  = s < 15 ? s - 12 : (s < 24 ? s - 15 : (s < 27 ? s - 13 : (s < 29 ? s - 26 : s - 25)));
			for (int w = 0; w < 3; w++)
				bus(1'b1, 6'(w), w == ix ? 32'h1 << b : 32'h0);
			settle();
			chk_out("enable bit", 36'h1 << s, {3'h0, src_req});
			chk_out("lone winner", {26'h0, 1'b1, 3'd1, 6'(s)}, {26'h0, irq_v, irq_l, irq_id});
		end
		$display("test enables done");
		conclude();
	end
endmodule : testbench
`default_nettype wire
